// *** hdl/eccp_capture_edge.sv ***
// capture edge qualifier with prescale
`timescale 1ns/1ps
`default_nettype none
module eccp_capture_edge
    import eccp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic [3:0] mode,
    input wire logic cap_in,
    // event
    output logic cap_event
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic prev;
        logic [3:0] count;
        logic ev;
    } cap_t;
    cap_t cur, nxt;
    logic rise;
    logic fall;

    // edge detect and prescale
    always_comb begin
        nxt = cur;
        rise = cap_in && !cur.prev;
        fall = !cap_in && cur.prev;
        nxt.prev = cap_in;
        nxt.ev = 1'b0;
        case (mode)
            MODE_CAP_FALL: nxt.ev = fall;
            MODE_CAP_RISE: nxt.ev = rise;
            MODE_CAP_4TH, MODE_CAP_16TH: begin
                if (rise) begin
                    nxt.count = cur.count + 4'h1;
                    nxt.ev = (mode == MODE_CAP_4TH) ? (cur.count[1:0] == 2'h3)
                                                    : (cur.count == 4'hF);
                end
            end
            default: nxt.count = 4'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign cap_event = cur.ev;
endmodule
`default_nettype wire

// *** hdl/eccp_pkg.sv ***
// package: register map, mode codes and field positions of the enhanced unit
package eccp_pkg;
    // apb byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_DUTY_HIGH = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_COMPARE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_PINCFG = 8'h14;
    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    // field positions in the control register
    localparam int BRIDGE_LSB = 6;
    localparam int DUTY_LOW_LSB = 4;
    // pin configuration register bits
    localparam int PIN_BUS_ACTIVE = 0;
    localparam int PIN_EXT_MODE = 1;
    localparam int PIN_BRIDGE_REMAP = 2;
    localparam int PIN_TWO_REMAP = 3;
    localparam int PIN_WIDTH_LSB = 4;
    localparam logic [7:0] PINCFG_RESET = 8'h0C;
    localparam logic [1:0] WIDTH_12BIT = 2'h1;
    // mode codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] MODE_SET_HIGH = 4'h8;
    localparam logic [3:0] MODE_SET_LOW = 4'h9;
    localparam logic [3:0] MODE_SOFT_INT = 4'hA;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    // bridge configurations
    localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
    localparam logic [1:0] BRIDGE_FWD = 2'h1;
    localparam logic [1:0] BRIDGE_HALF = 2'h2;
    localparam logic [1:0] BRIDGE_REV = 2'h3;
    // unit numbers
    localparam int UNIT_TWO = 2;
    localparam int UNIT_THREE = 3;
    // dead band in clock cycles
    localparam logic [3:0] DEAD_BAND_CYCLES = 4'h4;
endpackage

// *** hdl/eccp_pwm_core.sv ***
// pwm timebase with double-buffered 10-bit duty compare
`timescale 1ns/1ps
`default_nettype none
module eccp_pwm_core
    import eccp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic run,
    input wire logic [7:0] period,
    input wire logic [9:0] duty,
    // result
    output logic pwm_raw
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] timer; // 8-bit timer plus 2 low-order bits
        logic [9:0] shadow; // latched duty
        logic out;
    } core_t;
    core_t cur, nxt;

    // next-state logic
    always_comb begin
        nxt = cur;
        if (!run) begin
            nxt = '0;
        end else if (cur.timer == {period, 2'b11}) begin
            // period end: clear timer, latch duty, go active unless the new duty is zero
            nxt.timer = '0;
            nxt.shadow = duty;
            nxt.out = (duty != 10'h000);
        end else begin
            nxt.timer = cur.timer + 10'h001;
            // duty match ends the pulse; never matches if duty > {period, 2'b11}
            if (nxt.timer == cur.shadow) begin
                nxt.out = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
        end else begin
            cur <= nxt;
        end
    end

    assign pwm_raw = cur.out;

    a_duty_zero_low: assert property (@(posedge pclk) disable iff (!presetn)
        (run && cur.timer == {period, 2'b11} && duty == 10'h000) |=> !pwm_raw)
        else $error("zero duty must keep output inactive");
endmodule
`default_nettype wire

// *** hdl/eccp_unit.sv ***
// enhanced capture/compare/pwm unit: registers, mode decode and pin steering
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - mode 0000 switches off; 0001 reserved
// - modes 0100-0111 capture with edge prescale
// - mode 0010 toggles pin on match
// - mode 1000 starts low, match sets high
// - mode 1001 starts high, match sets low
// - mode 1010 flag only, pin to port
// - mode 1011 resets timer, unit two converts
// - unit three treats 1011 as 1010
// - pwm modes, bits 1/0 invert pairs
// - non-pwm ignores bridge field, A only
// - bridge 00: only A modulated
// - bridge 01: D modulated, A active
// - bridge 10: A,B modulated with dead band
// - bridge 11: B modulated, C active
// - bits 5-4 are duty low bits
// - active memory bus takes B,C pins
// - 12-bit bus width keeps pins free
// - cleared remap moves B,C to port H
// - unit two primary pin remap choices
// - quad output D overrides standard unit
// - period end clears, sets unless duty is zero, latches duty
// - duty match clears; overlong duty stays active
module eccp_unit
    import eccp_pkg::*;
#(
    parameter int UNIT_NUMBER = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // capture/compare timer interface
    input wire logic [15:0] capture_timer,
    input wire logic cap_in,
    output logic timer_reset,
    output logic start_conversion,
    input wire logic converter_enabled,
    // standard unit output being shared
    input wire logic standard_unit_out,
    // steered pins: enable high means the unit owns the pin
    output logic pin_primary,
    output logic pin_primary_en,
    output logic [2:0] pin_primary_sel,
    output logic pin_b,
    output logic pin_b_en,
    output logic pin_c,
    output logic pin_c_en,
    output logic pins_on_port_h,
    output logic pin_d,
    output logic pin_d_en,
    output logic standard_pin_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] control; // enhanced_unit_control
        logic [7:0] duty_high; // duty_high_byte
        logic [7:0] period; // pwm_period_register
        logic [15:0] compare; // compare value
        logic [7:0] pincfg; // remap and bus settings
        logic match_flag; // unit_match_flag
        logic [15:0] capture; // captured timer value
        logic cmp_pin; // compare-mode pin level
        logic [3:0] last_mode; // for entry detection
        logic [3:0] dead; // dead-band counter
        logic raw_q; // delayed pwm edge
        logic trig; // one-cycle special event
        logic [31:0] rdata;
    } unit_t;
    unit_t cur, nxt;

    logic [3:0] mode;
    logic [1:0] bridge;
    logic is_pwm;
    logic pwm_raw;
    logic cap_event;
    logic match;
    logic [31:0] wr_data;
    logic wr_en;
    logic act_ac;
    logic act_bd;
    logic mod_a;
    logic mod_b;
    logic bus_takes_bc;

    assign mode = cur.control[3:0];
    assign bridge = cur.control[BRIDGE_LSB +: 2];
    assign is_pwm = (mode[3:2] == 2'b11);
    assign match = (capture_timer == cur.compare);
    assign wr_data = pwdata;
    assign wr_en = psel && penable && pwrite;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    eccp_pwm_core i_eccp_pwm_core (
        .pclk(pclk),
        .presetn(presetn),
        .run(is_pwm),
        .period(cur.period),
        .duty({cur.duty_high, cur.control[DUTY_LOW_LSB +: 2]}),
        .pwm_raw(pwm_raw)
    );

    eccp_capture_edge i_eccp_capture_edge (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode),
        .cap_in(cap_in),
        .cap_event(cap_event)
    );

    // ------------------------------------------------------------
    // registers, compare and capture behaviour
    // ------------------------------------------------------------
    always_comb begin
        nxt = cur;
        nxt.trig = 1'b0;
        nxt.last_mode = mode;
        // apb writes take effect in the access phase
        if (wr_en) begin
            case (paddr)
                ADDR_CONTROL: nxt.control = wr_data[7:0];
                ADDR_DUTY_HIGH: nxt.duty_high = wr_data[7:0];
                ADDR_PERIOD: nxt.period = wr_data[7:0];
                ADDR_COMPARE: nxt.compare = wr_data[15:0];
                ADDR_PINCFG: nxt.pincfg = wr_data[7:0];
                ADDR_STATUS: begin
                    if (wr_data[0]) begin
                        nxt.match_flag = 1'b0;
                    end
                end
                default: nxt.control = cur.control;
            endcase
        end
        // mode behaviour; hardware set wins over software clear
        case (mode)
            MODE_OFF: begin
                // switched off: internal state reset
                nxt.cmp_pin = 1'b0;
                nxt.capture = '0;
            end
            MODE_TOGGLE: begin
                if (match) begin
                    nxt.cmp_pin = !cur.cmp_pin;
                    nxt.match_flag = 1'b1;
                end
            end
            MODE_SET_HIGH: begin
                if (cur.last_mode != mode) begin
                    nxt.cmp_pin = 1'b0;
                end else if (match) begin
                    nxt.cmp_pin = 1'b1;
                    nxt.match_flag = 1'b1;
                end
            end
            MODE_SET_LOW: begin
                if (cur.last_mode != mode) begin
                    nxt.cmp_pin = 1'b1;
                end else if (match) begin
                    nxt.cmp_pin = 1'b0;
                    nxt.match_flag = 1'b1;
                end
            end
            MODE_SOFT_INT: begin
                if (match) begin
                    nxt.match_flag = 1'b1;
                end
            end
            MODE_SPECIAL: begin
                if (match) begin
                    nxt.match_flag = 1'b1;
                    nxt.trig = (UNIT_NUMBER != UNIT_THREE);
                end
            end
            default: begin
                if (cap_event) begin
                    nxt.capture = capture_timer;
                    nxt.match_flag = 1'b1;
                end
            end
        endcase
        // dead band: count after each pwm edge
        nxt.raw_q = pwm_raw;
        if (pwm_raw != cur.raw_q) begin
            nxt.dead = DEAD_BAND_CYCLES;
        end else if (cur.dead != 4'h0) begin
            nxt.dead = cur.dead - 4'h1;
        end
        // read data captured in setup phase
        nxt.rdata = '0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_CONTROL: nxt.rdata = {24'h0000_00, cur.control};
                ADDR_DUTY_HIGH: nxt.rdata = {24'h0000_00, cur.duty_high};
                ADDR_PERIOD: nxt.rdata = {24'h0000_00, cur.period};
                ADDR_COMPARE: nxt.rdata = {16'h0000, cur.compare};
                ADDR_STATUS: nxt.rdata = {cur.capture, 15'h0000, cur.match_flag};
                ADDR_PINCFG: nxt.rdata = {24'h0000_00, cur.pincfg};
                default: nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.control <= CONTROL_RESET;
            cur.period <= PERIOD_RESET;
            cur.pincfg <= PINCFG_RESET;
        end else begin
            cur <= nxt;
        end
    end

    // apb answers: zero wait, error on unmapped address
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr > ADDR_PINCFG || paddr[1:0] != 2'b00);
    assign prdata = cur.rdata;
    assign timer_reset = cur.trig;
    assign start_conversion = cur.trig && (UNIT_NUMBER == UNIT_TWO) && converter_enabled;

    // ------------------------------------------------------------
    // output steering
    // ------------------------------------------------------------
    assign act_ac = !mode[1];
    assign act_bd = !mode[0];
    assign mod_a = pwm_raw && !(cur.raw_q != pwm_raw || cur.dead != 4'h0);
    assign mod_b = !pwm_raw && !(cur.raw_q != pwm_raw || cur.dead != 4'h0);
    // bus owns port E B/C unless 12-bit width or port H remap
    assign bus_takes_bc = cur.pincfg[PIN_BUS_ACTIVE] && cur.pincfg[PIN_EXT_MODE]
        && cur.pincfg[PIN_BRIDGE_REMAP]
        && cur.pincfg[PIN_WIDTH_LSB +: 2] != WIDTH_12BIT
        && UNIT_NUMBER != UNIT_TWO;
    assign pins_on_port_h = !cur.pincfg[PIN_BRIDGE_REMAP] && UNIT_NUMBER != UNIT_TWO;

    always_comb begin
        pin_primary = 1'b0;
        pin_primary_en = 1'b0;
        pin_b = 1'b0;
        pin_b_en = 1'b0;
        pin_c = 1'b0;
        pin_c_en = 1'b0;
        pin_d = 1'b0;
        pin_d_en = 1'b0;
        if (is_pwm) begin
            case (bridge)
                BRIDGE_SINGLE: begin
                    pin_primary = pwm_raw ~^ act_ac;
                    pin_primary_en = 1'b1;
                end
                BRIDGE_FWD: begin
                    pin_primary = act_ac;
                    pin_b = !act_bd;
                    pin_c = !act_ac;
                    pin_d = pwm_raw ~^ act_bd;
                    pin_primary_en = 1'b1;
                    pin_b_en = 1'b1;
                    pin_c_en = 1'b1;
                    pin_d_en = 1'b1;
                end
                BRIDGE_HALF: begin
                    pin_primary = mod_a ~^ act_ac;
                    pin_b = mod_b ~^ act_bd;
                    pin_primary_en = 1'b1;
                    pin_b_en = 1'b1;
                end
                default: begin
                    pin_primary = !act_ac;
                    pin_b = pwm_raw ~^ act_bd;
                    pin_c = act_ac;
                    pin_d = !act_bd;
                    pin_primary_en = 1'b1;
                    pin_b_en = 1'b1;
                    pin_c_en = 1'b1;
                    pin_d_en = 1'b1;
                end
            endcase
            if (bus_takes_bc) begin
                pin_b_en = 1'b0;
                pin_c_en = 1'b0;
            end
        end else if (mode == MODE_TOGGLE || mode == MODE_SET_HIGH || mode == MODE_SET_LOW) begin
            pin_primary = cur.cmp_pin;
            pin_primary_en = 1'b1;
        end
    end

    // primary pin location for unit two: 0 = port C1, 1 = E7, 2 = B3
    assign pin_primary_sel = (UNIT_NUMBER != UNIT_TWO || cur.pincfg[PIN_TWO_REMAP]) ? 3'h0 :
                             (cur.pincfg[PIN_EXT_MODE] ? 3'h2 : 3'h1);
    // quad output D replaces the standard unit pin
    assign standard_pin_out = (pin_d_en && UNIT_NUMBER != UNIT_TWO) ? pin_d : standard_unit_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_toggle_on_match: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_TOGGLE && $stable(mode) && match)
        |=> (cur.cmp_pin != $past(cur.cmp_pin)))
        else $error("toggle mode failed to toggle");
    a_set_high_match: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SET_HIGH && cur.last_mode == mode && match && !wr_en)
        |=> (cur.cmp_pin && cur.match_flag))
        else $error("set-high compare mismatch");
    a_set_low_match: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SET_LOW && cur.last_mode == mode && match && !wr_en)
        |=> (!cur.cmp_pin && cur.match_flag))
        else $error("set-low compare mismatch");
    a_soft_no_pin: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SOFT_INT) |-> !pin_primary_en)
        else $error("soft interrupt mode drove pin");
    a_special_trig: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SPECIAL && match) |=> (timer_reset == (UNIT_NUMBER != UNIT_THREE)))
        else $error("special event trigger wrong");
    a_single_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && bridge == BRIDGE_SINGLE) |-> (!pin_b_en && !pin_c_en && !pin_d_en))
        else $error("single output drove extra pins");
    a_off_no_pins: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_OFF) |-> (!pin_primary_en && !pin_d_en && !timer_reset))
        else $error("off mode drove a pin");
    a_quad_override: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && bridge[0] && UNIT_NUMBER != UNIT_TWO)
        |-> (pin_d_en && standard_pin_out == pin_d))
        else $error("quad output did not override");
endmodule
`default_nettype wire

// *** verif/bridge_drive_model.sv ***
// behavioural model of the external bridge leg fed by outputs A and B
`timescale 1ns/1ps
`default_nettype none
module bridge_drive_model (
    // clock
    input wire logic pclk,
    // high-side gate level and enable
    input wire logic hi_on,
    input wire logic hi_en,
    // low-side gate level and enable
    input wire logic lo_on,
    input wire logic lo_en,
    // resolved gate lines and shoot-through count
    output logic hi_wire,
    output logic lo_wire,
    output int overlap
);
    // ----------------------------------------
    // gate lines and overlap watch
    // ----------------------------------------
    logic pat = 1'b0; // wander pattern for a released gate line
    initial overlap = 0;
    // both switches on at once would short the supply
    always @(posedge pclk) begin
        pat <= ~pat;
        if (hi_en === 1'b1 && lo_en === 1'b1 && hi_on === 1'b1 && lo_on === 1'b1) begin
            overlap <= overlap + 1;
        end
    end
    // a pin not set to output leaves the gate floating
    assign hi_wire = (hi_en === 1'b1) ? hi_on : pat;
    assign lo_wire = (lo_en === 1'b1) ? lo_on : ~pat;
endmodule
`default_nettype wire

// *** verif/test_eccp_unit.sv ***
// self-checking bench for the enhanced unit: apb, compare, capture and pwm steering
`timescale 1ns/1ps
`default_nettype none
module test_eccp_unit;
    import eccp_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdv;
    logic pready, pslverr, timer_reset, start_conversion, cap_in = 1'b0, errv, p0;
    logic [15:0] capture_timer = 16'h0000;
    logic converter_enabled = 1'b1, standard_unit_out = 1'b0, standard_pin_out;
    logic pin_primary, pin_primary_en, pin_b, pin_b_en, pin_c, pin_c_en, pin_d, pin_d_en;
    logic pins_on_port_h, wire_a, wire_b;
    logic [2:0] pin_primary_sel;
    logic [3:0] caps [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_4TH, MODE_CAP_16TH};
    int edges [4] = '{1, 1, 4, 16};
    int bad_count = 0, n_tests = 0, tr_count = 0, sc_count = 0, overlap, n;
    // clock, toggling shared unit output and event counters
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        standard_unit_out <= ~standard_unit_out;
        if (timer_reset === 1'b1) tr_count <= tr_count + 1;
        if (start_conversion === 1'b1) sc_count <= sc_count + 1;
    end
    // ----------------------------------------
    // design and far-side model
    // ----------------------------------------
    eccp_unit #(.UNIT_NUMBER(1)) i_eccp_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_timer(capture_timer), .cap_in(cap_in),
        .timer_reset(timer_reset), .start_conversion(start_conversion),
        .converter_enabled(converter_enabled), .standard_unit_out(standard_unit_out),
        .pin_primary(pin_primary), .pin_primary_en(pin_primary_en),
        .pin_primary_sel(pin_primary_sel), .pin_b(pin_b), .pin_b_en(pin_b_en), .pin_c(pin_c),
        .pin_c_en(pin_c_en), .pins_on_port_h(pins_on_port_h), .pin_d(pin_d),
        .pin_d_en(pin_d_en), .standard_pin_out(standard_pin_out));
    bridge_drive_model i_bridge_drive_model (.pclk(pclk), .hi_on(pin_primary),
        .hi_en(pin_primary_en), .lo_on(pin_b), .lo_en(pin_b_en), .hi_wire(wire_a),
        .lo_wire(wire_b), .overlap(overlap));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdv, exp);
    endtask
    // read the match flag, then clear it
    task automatic flag_chk(input logic exp);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check(rdv[0], exp);
        wr(ADDR_STATUS, 32'h0000_0001);
    endtask
    // one cycle of timer equal to compare value
    task automatic match();
        @(posedge pclk);
        capture_timer <= 16'h0055;
        @(posedge pclk);
        capture_timer <= 16'h0000;
        repeat (3) @(posedge pclk);
    endtask
    task automatic pulse();
        @(posedge pclk);
        cap_in <= 1'b1;
        repeat (4) @(posedge pclk);
        cap_in <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    // run one pwm setting and count active cycles over two periods
    task automatic measure(input logic [1:0] pol, input logic [1:0] br, input logic [7:0] dh,
            input logic [1:0] dl, input int md);
        int ca = 0, cb = 0, cc = 0, cd = 0, sp = 0, ov, ea, eb, ec, ed;
        wr(ADDR_DUTY_HIGH, {24'h00_0000, dh});
        wr(ADDR_CONTROL, {24'h00_0000, br, dl, 2'h3, pol});
        repeat (40) @(posedge pclk);
        ov = overlap;
        repeat (32) begin
            @(negedge pclk);
            ca += wire_a;
            cb += wire_b;
            cc += pin_c;
            cd += pin_d;
            if (standard_pin_out !== (br[0] ? pin_d : standard_unit_out)) sp++;
        end
        ea = (br == BRIDGE_FWD) ? 32 : (br == BRIDGE_REV) ? 0 : md;
        eb = (br == BRIDGE_REV) ? md : 0;
        ec = (br == BRIDGE_REV) ? 32 : 0;
        ed = (br == BRIDGE_FWD) ? md : 0;
        if (pol[1]) ea = 32 - ea;
        if (pol[1]) ec = 32 - ec;
        if (pol[0]) eb = 32 - eb;
        if (pol[0]) ed = 32 - ed;
        check({pin_primary_en, pin_b_en, pin_c_en, pin_d_en},
            {1'b1, |br, br[0], br[0]});
        check(sp, 0);
        if (br == BRIDGE_HALF) check({ca != 0, cb != 0, overlap == ov || |pol}, 3'h7);
        else if (br == BRIDGE_SINGLE) check(ca, ea);
        else check({8'(ca), 8'(cb), 8'(cc), 8'(cd)},
            {8'(ea), 8'(eb), 8'(ec), 8'(ed)});
    endtask
    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ADDR_CONTROL, {24'h00_0000, CONTROL_RESET});
        rd_chk(ADDR_PINCFG, {24'h00_0000, PINCFG_RESET});
        check({pin_primary_en, pin_b_en, pin_c_en, pin_d_en}, 4'h0);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check({errv, rdv}, 33'h1_0000_0000);
        // compare modes
        wr(ADDR_COMPARE, 32'h0000_0055);
        wr(ADDR_CONTROL, {28'h000_0000, MODE_SET_LOW});
        check({pin_primary_en, pin_primary}, 2'h3);
        match();
        check({pin_primary_en, pin_primary}, 2'h2);
        flag_chk(1'b1);
        wr(ADDR_CONTROL, {28'h000_0000, MODE_SET_HIGH});
        check({pin_primary_en, pin_primary}, 2'h2);
        match();
        check({pin_primary_en, pin_primary}, 2'h3);
        flag_chk(1'b1);
        wr(ADDR_CONTROL, {28'h000_0000, MODE_TOGGLE});
        p0 = pin_primary;
        match();
        check(pin_primary, !p0);
        match();
        check(pin_primary, p0);
        wr(ADDR_CONTROL, {28'h000_0000, MODE_SOFT_INT});
        flag_chk(1'b1);
        n = tr_count;
        match();
        check({pin_primary_en, 31'(tr_count - n)}, 32'h0000_0000);
        flag_chk(1'b1);
        wr(ADDR_CONTROL, {28'h000_0000, MODE_SPECIAL});
        match();
        check({tr_count - n, sc_count}, {32'h0000_0001, 32'h0000_0000});
        flag_chk(1'b1);
        wr(ADDR_CONTROL, 32'h0000_0001);
        check(pin_primary_en, 1'b0);
        wr(ADDR_CONTROL, 32'h0000_00C2);
        check({pin_primary_en, pin_b_en, pin_c_en, pin_d_en}, 4'h8);
        // capture modes with edge prescale
        capture_timer <= 16'h1234;
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, {28'h000_0000, MODE_OFF});
            check(pin_primary_en, 1'b0);
            wr(ADDR_CONTROL, {28'h000_0000, caps[i]});
            wr(ADDR_STATUS, 32'h0000_0001);
            repeat (edges[i] - 1) pulse();
            rd_chk(ADDR_STATUS, 32'h0000_0000);
            pulse();
            rd_chk(ADDR_STATUS, 32'h1234_0001);
            check(pin_primary_en, 1'b0);
        end
        // pwm topologies and polarities
        wr(ADDR_PERIOD, 32'h0000_0003);
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 4; b++) measure(2'(p), 2'(b), 8'h01, 2'h2, 12);
        end
        measure(2'h0, BRIDGE_SINGLE, 8'hFF, 2'h3, 32);
        measure(2'h0, BRIDGE_SINGLE, 8'h00, 2'h0, 0);
        // pin mapping against the memory bus
        wr(ADDR_CONTROL, 32'h0000_006C);
        wr(ADDR_PINCFG, 32'h0000_000F);
        check({pin_b_en, pin_c_en}, 2'h0);
        wr(ADDR_PINCFG, 32'h0000_001F);
        check({pin_b_en, pin_c_en}, 2'h3);
        wr(ADDR_PINCFG, 32'h0000_000B);
        check({pins_on_port_h, pin_b_en}, 2'h3);
        wr(ADDR_PINCFG, 32'h0000_000C);
        check({pins_on_port_h, pin_primary_sel}, 4'h0);
        test_done();
    end
    // hang guard
    initial begin
        #200000;
        bad_count++;
        test_done();
    end
endmodule
`default_nettype wire
